// File: rtl/sync_source_detection.sv
/* host-side controller that sets up the digitizer sync slicers, polls the
 * activity and polarity registers and classifies the sync source.
 * assumes the device register port of reg_access_engine and one 20 MHz
 * clock shared with the device interface logic. */
// Summary of operation
// - line slicer code 001b rising, 110b falling
// - load green slicer setting with 0x16
// - classify in fixed priority, stop at first
// - line and frame active means separate sync
// - line only: composite on line, confirm
// - green only: composite on green, trilevel hint
// - nothing active means no valid sync
// - select composite source, check present flag
// - line and frame activity have top priority
// - green valid only while line inactive
// - trust trilevel only line 0, green 1
// - keep green low-pass filter enabled always
// - write 0x0f to standby to power down
`timescale 1ns/1ps
`default_nettype none
`include "sync_detect_defines.svh"

module sync_source_detection
	import sync_detect_pkg::*;
#(
	parameter int POLL_CYCLES = `POLL_TIME_US * `REF_CLK_MHZ,
	parameter int TRI_READS = `TRILEVEL_READS
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// user orders
	input wire logic start,
	input wire logic auto_poll,
	input wire logic channel_sel,
	input wire logic lock_falling,
	input wire logic phase_wr,
	input wire logic [5:0] phase_value,
	input wire logic standby_req,
	input wire logic standby_on,
	// user results
	output logic busy,
	output logic done,
	output logic [2:0] source_class,
	output logic composite_confirmed,
	output logic [7:0] activity_q,
	output logic [7:0] polarity_q,
	output logic [3:0] trilevel_votes,
	// device register port
	output logic reg_req,
	output logic reg_we,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic [7:0] reg_rdata
);

	reg_cmd_if cmd ();
	ctrl_state_e state_q;
	sync_source_e class_q;
	logic [31:0] wait_q;
	logic [3:0] tri_reads_q;
	logic channel_q;
	logic [1:0] cfg_src_q;
	logic [5:0] phase_q;
	logic stby_q;
	logic line_act, frame_act, green_act, tri_act;
	// pick the active-bit of a given field for the selected channel
	function automatic logic act_bit(input logic [7:0] st, input logic ch,
		input int pos);
		int idx;
		idx = ch ? pos + `ACT_CHANNEL_STRIDE : pos;
		return st[idx[2:0]];
	endfunction
	// ============================================================
	// register access engine
	reg_access_engine u_engine (
		.ref_clk(ref_clk), .resetn(resetn), .cmd(cmd),
		.reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata)
	);
	// ============================================================
	// decoded activity of the channel being classified
	assign line_act = act_bit(cmd.rdata, channel_q, `ACT_LINE_BIT);
	assign frame_act = act_bit(cmd.rdata, channel_q, `ACT_FRAME_BIT);
	assign green_act = act_bit(cmd.rdata, channel_q, `ACT_GREEN_BIT);
	assign tri_act = cmd.rdata[`ACT_TRILEVEL_BIT];

	// ============================================================
	// command for each register state; held until the engine is done
	always_comb begin
		cmd.valid = 1'b1;
		cmd.we = 1'b1;
		cmd.addr = 8'h00;
		cmd.wdata = 8'h00;
		case (state_q)
			ST_WR_GREEN: begin
				cmd.addr = `GREEN_SLICER_SETUP_ADDR;
				cmd.wdata = `GREEN_SLICER_DEFAULT; // lpf on
			end
			ST_WR_LSLICE: begin
				cmd.addr = `LINE_SLICER_SETUP_ADDR;
				cmd.wdata = {5'h00, lock_falling ? `LINE_SLICER_FALLING
					: `LINE_SLICER_RISING};
			end
			ST_WR_PHASE: begin
				cmd.addr = `SAMPLING_PHASE_SELECT_ADDR;
				cmd.wdata = {2'h0, phase_q};
			end
			ST_WR_CFG: begin
				cmd.addr = `INPUT_CONFIGURATION_ADDR;
				cmd.wdata = {3'h0, cfg_src_q, 2'h0, channel_q};
			end
			ST_WR_STBY: begin
				cmd.addr = `STANDBY_CONTROL_ADDR;
				cmd.wdata = stby_q ? `STANDBY_ENTER : `STANDBY_LEAVE;
			end
			ST_RD_ACT, ST_RD_CONF, ST_RD_TRI: begin
				cmd.we = 1'b0;
				cmd.addr = `SYNC_ACTIVITY_STATUS_ADDR;
			end
			ST_RD_POL: begin
				cmd.we = 1'b0;
				cmd.addr = `SYNC_POLARITY_STATUS_ADDR;
			end
			default: cmd.valid = 1'b0;
		endcase
	end

	// ============================================================
	// sequencer
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (standby_req) begin
						state_q <= ST_WR_STBY;
					end else if (phase_wr) begin
						state_q <= ST_WR_PHASE;
					end else if (start) begin
						state_q <= ST_WR_GREEN;
					end
				end
				ST_WR_GREEN: if (cmd.done) state_q <= ST_WR_LSLICE;
				ST_WR_LSLICE: if (cmd.done) state_q <= ST_RD_ACT;
				ST_WR_PHASE: if (cmd.done) state_q <= ST_IDLE;
				ST_WR_STBY: if (cmd.done) state_q <= ST_IDLE;
				ST_RD_ACT: if (cmd.done) state_q <= ST_RD_POL;
				ST_RD_POL: if (cmd.done) state_q <= ST_CLASSIFY;
				ST_CLASSIFY: begin
					// first match wins
					if (class_q == SRC_COMP_LINE || class_q == SRC_COMP_GREEN) begin
						state_q <= ST_WR_CFG;
					end else begin
						state_q <= ST_FINISH;
					end
				end
				ST_WR_CFG: if (cmd.done) state_q <= ST_RD_CONF;
				ST_RD_CONF: begin
					if (cmd.done) begin
						state_q <= (class_q == SRC_COMP_GREEN) ? ST_RD_TRI
							: ST_FINISH;
					end
				end
				ST_RD_TRI: begin
					if (cmd.done && tri_reads_q == 4'(TRI_READS - 1)) begin
						state_q <= ST_FINISH;
					end
				end
				ST_FINISH: state_q <= auto_poll ? ST_WAIT : ST_IDLE;
				ST_WAIT: begin
					// repeated polling notices a source that went away
					if (!auto_poll || standby_req) begin
						state_q <= ST_IDLE;
					end else if (wait_q == 32'(POLL_CYCLES - 1)) begin
						state_q <= ST_RD_ACT;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// user settings latched when an order is taken
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			channel_q <= 1'b0;
			phase_q <= 6'h00;
			stby_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			if (standby_req) begin
				stby_q <= standby_on;
			end else if (phase_wr) begin
				phase_q <= phase_value;
			end else if (start) begin
				channel_q <= channel_sel;
			end
		end
	end

	// ============================================================
	// status capture and classification
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			class_q <= SRC_NONE;
			cfg_src_q <= `CFG_SRC_SEPARATE;
			activity_q <= 8'h00;
			polarity_q <= 8'h00;
			composite_confirmed <= 1'b0;
		end else if (cmd.done) begin
			case (state_q)
				ST_RD_ACT: begin
					activity_q <= cmd.rdata;
					composite_confirmed <= 1'b0;
					// line+frame outrank green
					if (line_act && frame_act) begin
						class_q <= SRC_SEPARATE;
						composite_confirmed <= 1'b1;
					end else if (line_act) begin
						// green ignored when line active
						class_q <= SRC_COMP_LINE;
						cfg_src_q <= `CFG_SRC_COMP_LINE;
					end else if (green_act) begin
						class_q <= SRC_COMP_GREEN;
						cfg_src_q <= `CFG_SRC_COMP_GREEN;
					end else begin
						class_q <= SRC_NONE;
					end
				end
				ST_RD_POL: polarity_q <= cmd.rdata;
				ST_RD_CONF: begin
					activity_q <= cmd.rdata;
					composite_confirmed <= cmd.rdata[`ACT_COMPOSITE_BIT];
				end
				ST_RD_TRI: begin
					if (tri_act && !line_act && green_act) begin
						class_q <= SRC_COMP_GREEN_TRI;
					end
				end
				default: ;
			endcase
		end
	end

	// ============================================================
	// trilevel read count and votes; several reads raise confidence
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tri_reads_q <= 4'h0;
			trilevel_votes <= 4'h0;
		end else if (state_q == ST_RD_ACT) begin
			tri_reads_q <= 4'h0;
			trilevel_votes <= 4'h0;
		end else if (state_q == ST_RD_TRI && cmd.done) begin
			tri_reads_q <= tri_reads_q + 4'h1;
			// vote counts only while line 0 and green 1
			if (tri_act && !line_act && green_act) begin
				trilevel_votes <= trilevel_votes + 4'h1;
			end
		end
	end

	// ============================================================
	// poll interval counter; runs only while waiting between polls
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) wait_q <= 32'h0;
		else wait_q <= (state_q == ST_WAIT) ? wait_q + 32'h1 : 32'h0;
	end
	// ============================================================
	// user outputs
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) done <= 1'b0;
		else done <= (state_q == ST_FINISH);
	end

	assign busy = (state_q != ST_IDLE) && (state_q != ST_WAIT);
	assign source_class = class_q;

endmodule

`default_nettype wire

// File: rtl/sync_detect_defines.svh
/*
 * register map, field positions, command values and timing counts for the
 * sync source detection controller.
 * assumes the device register space is byte wide with 8-bit offsets.
 */
`ifndef SYNC_DETECT_DEFINES_SVH
`define SYNC_DETECT_DEFINES_SVH

// ============================================================
// register offsets in the device
`define SYNC_ACTIVITY_STATUS_ADDR 8'h01
`define SYNC_POLARITY_STATUS_ADDR 8'h02
`define LINE_SLICER_SETUP_ADDR 8'h03
`define GREEN_SLICER_SETUP_ADDR 8'h04
`define INPUT_CONFIGURATION_ADDR 8'h05
`define SAMPLING_PHASE_SELECT_ADDR 8'h10
`define STANDBY_CONTROL_ADDR 8'h1b

// ============================================================
// values written to the device
`define GREEN_SLICER_DEFAULT 8'h16
`define GREEN_SLICER_LPF_BIT 4
`define LINE_SLICER_RISING 3'h1
`define LINE_SLICER_FALLING 3'h6
`define STANDBY_ENTER 8'h0f
`define STANDBY_LEAVE 8'h00
`define PHASE_STEPS 64

// ============================================================
// activity status field layout, channel 1 fields sit 3 bits higher
`define ACT_LINE_BIT 0
`define ACT_FRAME_BIT 1
`define ACT_GREEN_BIT 2
`define ACT_CHANNEL_STRIDE 3
`define ACT_TRILEVEL_BIT 6
`define ACT_COMPOSITE_BIT 7

// ============================================================
// input configuration fields: bit 0 channel, bits 4:3 composite source
`define CFG_CHANNEL_BIT 0
`define CFG_SRC_LSB 3
`define CFG_SRC_SEPARATE 2'h0
`define CFG_SRC_COMP_LINE 2'h1
`define CFG_SRC_COMP_GREEN 2'h2

// ============================================================
// timing
`define REF_CLK_MHZ 20
`define POLL_TIME_US 1000
`define TRILEVEL_READS 4

`endif

// File: rtl/sync_detect_pkg.sv
/*
 * types shared by the sync source detection controller.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package sync_detect_pkg;

	// ============================================================
	// controller sequencer states, one-hot
	typedef enum logic [12:0] {
		ST_IDLE = 13'h0001,
		ST_WR_GREEN = 13'h0002,
		ST_WR_LSLICE = 13'h0004,
		ST_WR_PHASE = 13'h0008,
		ST_RD_ACT = 13'h0010,
		ST_RD_POL = 13'h0020,
		ST_CLASSIFY = 13'h0040,
		ST_WR_CFG = 13'h0080,
		ST_RD_CONF = 13'h0100,
		ST_RD_TRI = 13'h0200,
		ST_FINISH = 13'h0400,
		ST_WAIT = 13'h0800,
		ST_WR_STBY = 13'h1000
	} ctrl_state_e;

	// ============================================================
	// classification outcome
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_SEPARATE = 3'h1,
		SRC_COMP_LINE = 3'h2,
		SRC_COMP_GREEN = 3'h3,
		SRC_COMP_GREEN_TRI = 3'h4
	} sync_source_e;

	// ============================================================
	// register engine states, one-hot
	typedef enum logic [2:0] {
		EN_IDLE = 3'h1,
		EN_BUSY = 3'h2,
		EN_DONE = 3'h4
	} engine_state_e;

endpackage

// File: rtl/reg_cmd_if.sv
/*
 * carries one register command from the sequencer to the access engine.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface reg_cmd_if;
	logic valid;
	logic we;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;

	// ============================================================
	// sequencer issues, engine executes
	modport master (output valid, output we, output addr, output wdata,
		input done, input rdata);
	modport engine (input valid, input we, input addr, input wdata,
		output done, output rdata);
endinterface

`default_nettype wire

// File: rtl/reg_access_engine.sv
/*
 * runs one register read or write on the device register port.
 * assumes the device answers every held request with a one-cycle ack.
 */
`timescale 1ns/1ps
`default_nettype none

module reg_access_engine
	import sync_detect_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// command side
	reg_cmd_if.engine cmd,
	// device register port
	output logic reg_req,
	output logic reg_we,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic reg_ack,
	input wire logic [7:0] reg_rdata
);

	engine_state_e state_q;
	logic [7:0] rdata_q;

	// ============================================================
	// request held until ack; done stands one cycle so no re-accept
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= EN_IDLE;
			reg_we <= 1'b0;
			reg_addr <= 8'h00;
			reg_wdata <= 8'h00;
		end else begin
			case (state_q)
				EN_IDLE: begin
					if (cmd.valid) begin
						state_q <= EN_BUSY;
						reg_we <= cmd.we;
						reg_addr <= cmd.addr;
						reg_wdata <= cmd.wdata;
					end
				end
				EN_BUSY: begin
					if (reg_ack) begin
						state_q <= EN_DONE;
					end
				end
				EN_DONE: state_q <= EN_IDLE;
				default: state_q <= EN_IDLE;
			endcase
		end
	end

	// read data captured with the ack
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_q <= 8'h00;
		end else if (state_q == EN_BUSY && reg_ack && !reg_we) begin
			rdata_q <= reg_rdata;
		end
	end

	assign reg_req = (state_q == EN_BUSY);
	assign cmd.done = (state_q == EN_DONE);
	assign cmd.rdata = rdata_q;

endmodule

`default_nettype wire

// File: verif/sync_source_detection_props.sv
/* port assertions for the sync source controller.
   assumes one clock and the register port hand-over. */
`timescale 1ns/1ps
`default_nettype none

module sync_source_detection_props (
	// clock, reset and orders
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic lock_falling,
	input wire logic [5:0] phase_value,
	input wire logic standby_on,
	// results
	input wire logic busy,
	input wire logic done,
	input wire logic [2:0] source_class,
	input wire logic composite_confirmed,
	input wire logic [7:0] activity_q,
	// device register port
	input wire logic reg_req,
	input wire logic reg_we,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_ack
);
	// ==========================================================
	// one domain, reset silences every check
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	logic wr;
	assign wr = reg_req && reg_we;

	// ==========================================================
	// request held whole until the answer
	req_hold_a: assert property (reg_req && !reg_ack |=> reg_req
		&& $stable(reg_we) && $stable(reg_addr) && $stable(reg_wdata))
		else $error("request changed before ack");
	req_gap_a: assert property (reg_req && reg_ack |=> !reg_req [*2])
		else $error("request not released for two cycles");
	green_value_a: assert property (
		wr && reg_addr == 8'h04 |-> reg_wdata == 8'h16 && reg_wdata[4])
		else $error("green slicer value wrong");
	line_code_a: assert property (
		wr && reg_addr == 8'h03 |->
		reg_wdata[2:0] == (lock_falling ? 3'h6 : 3'h1))
		else $error("line slicer code wrong");
	phase_value_a: assert property (
		wr && reg_addr == 8'h10 |-> reg_wdata == {2'h0, phase_value})
		else $error("phase value wrong");
	standby_code_a: assert property (
		wr && reg_addr == 8'h1b |->
		reg_wdata == (standby_on ? 8'h0f : 8'h00))
		else $error("standby value wrong");
	separate_conf_a: assert property (
		done && source_class == 3'h1 |-> composite_confirmed)
		else $error("separate sync not confirmed");
	none_class_a: assert property (
		done && activity_q[6:0] == 7'h00 |-> source_class == 3'h0)
		else $error("quiet inputs not classed as none");
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
	busy_access_a: assert property (reg_req |-> busy)
		else $error("access while not busy");
endmodule

bind sync_source_detection sync_source_detection_props props_i (
	.ref_clk, .resetn, .lock_falling, .phase_value, .standby_on, .busy,
	.done, .source_class, .composite_confirmed, .activity_q, .reg_req,
	.reg_we, .reg_addr, .reg_wdata, .reg_ack);

`default_nettype wire

// File: verif/device_reg_model.sv
/* behavioural register side of the digitizer sync detectors.
   assumes one access at a time, held until ack. */
`timescale 1ns/1ps
`default_nettype none

module device_reg_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// device register port
	input wire logic reg_req,
	input wire logic reg_we,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic reg_ack,
	output logic [7:0] reg_rdata,
	// detector view of the sync inputs, and answer delay
	input wire logic [6:0] sync_stat,
	input wire logic [7:0] sync_pol,
	input wire logic comp_ok,
	input wire logic [3:0] ack_wait
);
	logic [7:0] line_q, green_q, cfg_q, phase_q, stby_q;
	logic [3:0] cnt_q;
	logic [2:0] li;
	logic comp;
	// ==========================================================
	// composite flag needs a selected, live composite source
	assign li = cfg_q[0] ? 3'h3 : 3'h0;
	assign comp = comp_ok && ((cfg_q[4:3] == 2'h1 && sync_stat[li]) ||
		(cfg_q[4:3] == 2'h2 && sync_stat[li + 3'h2]));

	// answer after ack_wait cycles; released data toggles so no
	// stale byte can pass for a fresh one
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_ack <= 1'b0;
			reg_rdata <= 8'h00;
			cnt_q <= 4'h0;
			line_q <= 8'h00;
			green_q <= 8'h00;
			cfg_q <= 8'h00;
			phase_q <= 8'h00;
			stby_q <= 8'h00;
		end else begin
			reg_ack <= 1'b0;
			reg_rdata <= ~reg_rdata;
			if (reg_req && !reg_ack && cnt_q != ack_wait) begin
				cnt_q <= cnt_q + 4'h1;
			end else if (reg_req && !reg_ack) begin
				cnt_q <= 4'h0;
				reg_ack <= 1'b1;
				if (reg_we) begin
					case (reg_addr)
						8'h03: line_q <= reg_wdata;
						8'h04: green_q <= reg_wdata;
						8'h05: cfg_q <= reg_wdata;
						8'h10: phase_q <= reg_wdata;
						8'h1b: stby_q <= reg_wdata;
						default: ;
					endcase
				end else begin
					// detectors run whatever the standby state; status bits
					// stand for glitch-filtered inputs, the raw sync
					// and marker outputs never pass through here
					case (reg_addr)
						8'h01: reg_rdata <= {comp, sync_stat};
						8'h02: reg_rdata <= sync_pol;
						8'h04: reg_rdata <= green_q;
						8'h05: reg_rdata <= cfg_q;
						8'h10: reg_rdata <= phase_q;
						default: reg_rdata <= 8'h00;
					endcase
				end
			end
		end
	end
endmodule

`default_nettype wire

// File: verif/sync_source_detection_tb.sv
/* self-checking bench for the sync source controller.
   assumes the device model answers the register port. */
`timescale 1ns/1ps
`default_nettype none

module sync_source_detection_tb;
	import sync_detect_pkg::*;
	logic ref_clk, resetn, start, auto_poll, channel_sel, lock_falling;
	logic phase_wr, standby_req, standby_on, comp_ok;
	logic [5:0] phase_value;
	logic [6:0] sync_stat;
	logic [7:0] sync_pol;
	logic [3:0] ack_wait;
	logic busy, done, composite_confirmed, reg_req, reg_we, reg_ack;
	logic [2:0] source_class;
	logic [7:0] activity_q, polarity_q, reg_addr, reg_wdata, reg_rdata;
	logic [3:0] trilevel_votes;
	int bad_count = 0;
	int compares = 0;
	// case table: {comp_ok, lock_falling, channel, status}
	logic [9:0] cases [10] = '{10'h003, 10'h107, 10'h201, 10'h005,
		10'h204, 10'h244, 10'h040, 10'h288, 10'h2a3, 10'h080};

	// ==========================================================
	// short poll period keeps the auto poll test quick
	sync_source_detection #(.POLL_CYCLES(20), .TRI_READS(4)) uut (
		.ref_clk, .resetn, .start, .auto_poll, .channel_sel,
		.lock_falling, .phase_wr, .phase_value, .standby_req, .standby_on,
		.busy, .done, .source_class, .composite_confirmed, .activity_q,
		.polarity_q, .trilevel_votes, .reg_req, .reg_we, .reg_addr,
		.reg_wdata, .reg_ack, .reg_rdata);
	device_reg_model m (.ref_clk, .resetn, .reg_req, .reg_we, .reg_addr,
		.reg_wdata, .reg_ack, .reg_rdata, .sync_stat, .sync_pol, .comp_ok,
		.ack_wait);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// helpers: inputs move and outputs are read 2 ns after the edge
	task automatic tick();
		@(posedge ref_clk);
		#2;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wait_for(input logic want_done);
		int n;
		n = 0;
		do begin
			tick();
			n++;
		end while ((want_done ? done !== 1'b1 : busy !== 1'b0) && n < 3000);
		chk(n < 3000, 1'b1);
	endtask
	task automatic complete_run();
		if (bad_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic run_case(input logic [9:0] c);
		logic l, f, g, t;
		logic [2:0] ec;
		l = c[7] ? c[3] : c[0];
		f = c[7] ? c[4] : c[1];
		g = c[7] ? c[5] : c[2];
		t = c[6];
		ec = (l && f) ? 3'h1 : l ? 3'h2 : g ? (t ? 3'h4 : 3'h3) : 3'h0;
		{comp_ok, lock_falling, channel_sel, sync_stat} = c;
		start = 1'b1;
		tick();
		start = 1'b0;
		wait_for(1'b1);
		chk(source_class, ec);
		chk(activity_q & 8'h7f, {1'b0, c[6:0]});
		chk(polarity_q, sync_pol);
		chk(m.line_q[2:0], c[8] ? 3'h6 : 3'h1);
		chk(m.green_q, 8'h16);
		if (ec == 3'h1) chk(composite_confirmed, 1'b1);
		if (ec > 3'h1) begin
			chk(composite_confirmed, c[9]);
			chk(m.cfg_q[4:0], {ec == 3'h2 ? 2'h1 : 2'h2, 2'h0, c[7]});
		end
		if (ec > 3'h2) chk(trilevel_votes, t ? 4'h4 : 4'h0);
	endtask
	task automatic set_phase(input logic [5:0] v);
		phase_value = v;
		phase_wr = 1'b1;
		tick();
		phase_wr = 1'b0;
		wait_for(1'b0);
		chk(m.phase_q, {2'h0, v});
	endtask
	task automatic set_standby(input logic on);
		standby_on = on;
		standby_req = 1'b1;
		auto_poll = 1'b0;
		tick();
		standby_req = 1'b0;
		wait_for(1'b0);
		chk(m.stby_q, on ? 8'h0f : 8'h00);
	endtask
	task automatic poll_then_loss();
		auto_poll = 1'b1;
		run_case(10'h003);
		sync_stat = 7'h00;
		wait_for(1'b1);
		chk(source_class, 3'h0);
		chk(activity_q, 8'h00);
		// leave the poll wait so the next order is taken in idle
		auto_poll = 1'b0;
		tick();
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{resetn, start, auto_poll, channel_sel, lock_falling} = 5'h0;
		{phase_wr, standby_req, standby_on, comp_ok} = 4'h0;
		{phase_value, sync_stat, ack_wait} = 17'h0;
		sync_pol = 8'h5a;
		repeat (20) @(posedge ref_clk);
		#2;
		resetn = 1'b1;
		tick();
		for (int i = 0; i < 10; i++) begin
			ack_wait = 4'(i % 4);
			run_case(cases[i]);
		end
		set_phase(6'h00);
		set_phase(6'h3f);
		set_phase(6'h2a);
		poll_then_loss();
		set_standby(1'b1);
		run_case(10'h201);
		set_standby(1'b0);
		complete_run();
	end

	// watchdog well past the expected run length
	initial begin
		#(60000 * 50);
		bad_count++;
		complete_run();
	end
endmodule

`default_nettype wire
